// ---- verilog/modbus_cfg_pkg.sv ----
// constants, register map and state types for the modbus slave link configuration block
// assumes a 200 MHz aclk and an axi4-lite master with 32-bit data
package modbus_cfg_pkg;

	// clock and time units
	localparam int CLK_FREQ_HZ = 200000000;
	localparam int LOSS_UNIT_MS = 100;
	localparam int LOSS_UNIT_CYCLES = CLK_FREQ_HZ / 1000 * LOSS_UNIT_MS;
	localparam int TURN_UNIT_MS = 1;
	localparam int TURN_UNIT_CYCLES = CLK_FREQ_HZ / 1000 * TURN_UNIT_MS;
	localparam int LOSS_PRE_W = 25;
	localparam int TURN_PRE_W = 18;

	// register byte offsets
	localparam logic [7:0] OFS_STATION = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_FORMAT = 8'h08;
	localparam logic [7:0] OFS_TIMEOUT = 8'h0C;
	localparam logic [7:0] OFS_TURN = 8'h10;
	localparam logic [7:0] OFS_ACTION = 8'h14;
	localparam logic [7:0] OFS_SOURCE = 8'h18;
	localparam logic [7:0] OFS_ACTIVE = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STS = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

	// source register field positions
	localparam int FREQ_PRI_LSB = 0;
	localparam int RUN_PRI_LSB = 4;
	localparam int FREQ_SEC_LSB = 8;
	localparam int RUN_SEC_LSB = 12;

	// active register field positions
	localparam int ACT_BAUD_LSB = 8;
	localparam int ACT_ASCII = 12;
	localparam int ACT_DATA7 = 13;
	localparam int ACT_PAR_EN = 14;
	localparam int ACT_PAR_ODD = 15;
	localparam int ACT_TWO_STOP = 16;
	localparam int ACT_FAULT = 17;
	localparam int ACT_MB_FREQ = 18;
	localparam int ACT_MB_RUN = 19;

	// interrupt bits
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_ACCEPT = 1;
	localparam int IRQ_DROP = 2;

	// reset values and limits
	localparam logic [4:0] STATION_RST = 5'h01;
	localparam logic [3:0] BAUD_RST = 4'h3;
	localparam logic [3:0] BAUD_MAX = 4'h8;
	localparam logic [3:0] FMT_RST = 4'h1;
	localparam logic [3:0] FMT_MAX = 4'hB;
	localparam logic [3:0] FMT_ASCII8 = 4'h4;
	localparam logic [3:0] FMT_ASCII7 = 4'h8;
	localparam logic [7:0] TIMEOUT_MAX = 8'h64;
	localparam logic [2:0] FREQ_PRI_RST = 3'h1;
	localparam logic [1:0] RUN_PRI_RST = 2'h1;
	localparam logic [2:0] FREQ_SEC_RST = 3'h0;
	localparam logic [1:0] RUN_SEC_RST = 2'h0;
	localparam logic [2:0] FREQ_SRC_MAX = 3'h4;
	localparam logic [1:0] RUN_SRC_MAX = 2'h2;
	localparam logic [2:0] FREQ_MODBUS = 3'h3;
	localparam logic [1:0] RUN_MODBUS = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TA_IDLE = 2'h0,
		TA_WAIT = 2'h1,
		TA_READY = 2'h3
	} ta_state_e;

	// received frame report from the framer
	typedef struct packed {
		logic done;
		logic crc_ok;
		logic writes_comm;
		logic [7:0] addr;
	} frame_in_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [4:0] addr_pend;
		logic [3:0] baud_pend;
		logic [4:0] addr_act;
		logic [3:0] baud_act;
		logic [3:0] frame_fmt;
		logic ascii;
		logic data7;
		logic par_en;
		logic par_odd;
		logic two_stop;
		logic [6:0] timeout;
		logic [7:0] turnaround;
		logic [1:0] fault_action;
		logic [2:0] freq_pri;
		logic [1:0] run_pri;
		logic [2:0] freq_sec;
		logic [1:0] run_sec;
		logic [2:0] eff_freq;
		logic [1:0] eff_run;
		logic modbus_freq;
		logic modbus_run;
		logic comm_fault;
		logic frame_accept;
		logic frame_write_ok;
		logic tx_start;
		ta_state_e ta_state;
		logic [2:0] irq_sts;
		logic [2:0] irq_mask;
		logic irq;
	} top_state_s;

	localparam top_state_s TOP_RST = '{
		awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
		arready: 1'b1, rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0,
		aw_got: 1'b0, w_got: 1'b0, awaddr: 8'h00, wdata: 32'h0, wstrb: 4'h0,
		addr_pend: STATION_RST, baud_pend: BAUD_RST, addr_act: STATION_RST, baud_act: BAUD_RST,
		frame_fmt: FMT_RST, ascii: 1'b0, data7: 1'b0, par_en: 1'b0, par_odd: 1'b0, two_stop: 1'b0,
		timeout: 7'h00, turnaround: 8'h00, fault_action: 2'h0,
		freq_pri: FREQ_PRI_RST, run_pri: RUN_PRI_RST, freq_sec: FREQ_SEC_RST, run_sec: RUN_SEC_RST,
		eff_freq: FREQ_PRI_RST, eff_run: RUN_PRI_RST, modbus_freq: 1'b0, modbus_run: 1'b0,
		comm_fault: 1'b0, frame_accept: 1'b0, frame_write_ok: 1'b0, tx_start: 1'b0,
		ta_state: TA_IDLE, irq_sts: 3'h0, irq_mask: 3'h0, irq: 1'b0
	};

endpackage

// ---- verilog/timer_count.sv ----
// loadable down counter with zero flag, used for prescalers and timeouts
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module timer_count #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic dec,
	// status
	output logic zero
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (dec && cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign zero = (cnt_q == '0);

endmodule

// ---- verilog/modbus_slave_link_config.sv ----
// modbus serial slave configuration, station filter, loss supervision and turnaround timing
// assumes a framer that reports each received frame and an axi4-lite master for settings
//
// Contract
// - hold station address 1..31, default 1; accept only frames with that address
// - station address zero means no request is ever answered
// - new address and baud settings apply only after a power-up reload
// - baud selector codes 0..8, default 3 meaning 9600 bit/s
// - format codes 0..3 are rtu 8 bits: n2, n1, e1, o1; default 1
// - format codes 4..7 are ascii 8 bits in the same parity and stop order
// - format codes 8..11 are ascii 7 bits, same order; above 11 invalid
// - loss timeout 0.0..10.0 s, default 0.0; zero disables detection
// - no valid frame within timeout raises comm fault with chosen fault action
// - programmable wait between end of request and start of own transmission
// - frequency source codes 0..4, default 1, code 3 is modbus
// - run source codes 0..2, default 1, code 2 is modbus
// - secondary sources default 0, used only when input code 4 and dip off
// - master may always monitor and change parameters except communication ones
`timescale 1ns/1ps
module modbus_slave_link_config #(
	parameter int LOSS_TICK_CYCLES = modbus_cfg_pkg::LOSS_UNIT_CYCLES,
	parameter int TURN_TICK_CYCLES = modbus_cfg_pkg::TURN_UNIT_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// power-up and source inputs
	input wire logic power_up_reload,
	input wire logic mfi_source_switch,
	input wire logic dip_off,
	// framer side
	input wire modbus_cfg_pkg::frame_in_s frame_in,
	input wire logic tx_request,
	output logic frame_accept,
	output logic frame_write_ok,
	output logic tx_start,
	// serial configuration
	output logic [3:0] baud_select,
	output logic ascii_mode,
	output logic data_bits_7,
	output logic parity_en,
	output logic parity_odd,
	output logic two_stop,
	// supervision and sources
	output logic comm_fault,
	output logic [1:0] comm_fault_action,
	output logic [2:0] freq_ref_source,
	output logic [1:0] run_cmd_source,
	output logic modbus_freq_sel,
	output logic modbus_run_sel,
	output logic irq
);

	modbus_cfg_pkg::top_state_s q;
	modbus_cfg_pkg::top_state_s d;
	logic tick_loss;
	logic tick_turn;
	logic loss_zero;
	logic turn_zero;
	logic loss_en;
	logic loss_load;
	logic frame_match;
	logic [2:0] eff_freq_c;
	logic [1:0] eff_run_c;

	function automatic logic [31:0] reg_value(input logic [7:0] a, input modbus_cfg_pkg::top_state_s s);
		logic [31:0] v;
		v = 32'h0;
		case (a)
			modbus_cfg_pkg::OFS_STATION: v[4:0] = s.addr_pend;
			modbus_cfg_pkg::OFS_BAUD: v[3:0] = s.baud_pend;
			modbus_cfg_pkg::OFS_FORMAT: v[3:0] = s.frame_fmt;
			modbus_cfg_pkg::OFS_TIMEOUT: v[6:0] = s.timeout;
			modbus_cfg_pkg::OFS_TURN: v[7:0] = s.turnaround;
			modbus_cfg_pkg::OFS_ACTION: v[1:0] = s.fault_action;
			modbus_cfg_pkg::OFS_SOURCE: begin
				v[modbus_cfg_pkg::FREQ_PRI_LSB +: 3] = s.freq_pri;
				v[modbus_cfg_pkg::RUN_PRI_LSB +: 2] = s.run_pri;
				v[modbus_cfg_pkg::FREQ_SEC_LSB +: 3] = s.freq_sec;
				v[modbus_cfg_pkg::RUN_SEC_LSB +: 2] = s.run_sec;
			end
			modbus_cfg_pkg::OFS_ACTIVE: begin
				v[4:0] = s.addr_act;
				v[modbus_cfg_pkg::ACT_BAUD_LSB +: 4] = s.baud_act;
				v[modbus_cfg_pkg::ACT_ASCII] = s.ascii;
				v[modbus_cfg_pkg::ACT_DATA7] = s.data7;
				v[modbus_cfg_pkg::ACT_PAR_EN] = s.par_en;
				v[modbus_cfg_pkg::ACT_PAR_ODD] = s.par_odd;
				v[modbus_cfg_pkg::ACT_TWO_STOP] = s.two_stop;
				v[modbus_cfg_pkg::ACT_FAULT] = s.comm_fault;
				v[modbus_cfg_pkg::ACT_MB_FREQ] = s.modbus_freq;
				v[modbus_cfg_pkg::ACT_MB_RUN] = s.modbus_run;
			end
			modbus_cfg_pkg::OFS_IRQ_STS: v[2:0] = s.irq_sts;
			modbus_cfg_pkg::OFS_IRQ_MASK: v[2:0] = s.irq_mask;
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	function automatic logic addr_known(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= modbus_cfg_pkg::OFS_IRQ_MASK);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// timers

	timer_count #(.W(modbus_cfg_pkg::LOSS_PRE_W)) u_loss_pre (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(tick_loss),
		.load_val(modbus_cfg_pkg::LOSS_PRE_W'(LOSS_TICK_CYCLES - 1)),
		.dec(1'b1),
		.zero(tick_loss)
	);

	timer_count #(.W(modbus_cfg_pkg::TURN_PRE_W)) u_turn_pre (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(tick_turn),
		.load_val(modbus_cfg_pkg::TURN_PRE_W'(TURN_TICK_CYCLES - 1)),
		.dec(1'b1),
		.zero(tick_turn)
	);

	assign loss_en = (q.timeout != 7'h00);
	assign loss_load = (d.timeout == 7'h00) || (d.timeout != q.timeout) || frame_match;

	timer_count #(.W(7)) u_loss (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(loss_load),
		.load_val(d.timeout),
		.dec(tick_loss),
		.zero(loss_zero)
	);

	timer_count #(.W(8)) u_turn (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(frame_match),
		.load_val(q.turnaround),
		.dec(tick_turn),
		.zero(turn_zero)
	);

	////////////////////////////////////////////////////////////////////////
	// frame filter and sources

	assign frame_match = frame_in.done && frame_in.crc_ok && (q.addr_act != 5'h00) &&
		(frame_in.addr == {3'h0, q.addr_act});
	assign eff_freq_c = (mfi_source_switch && dip_off) ? q.freq_sec : q.freq_pri;
	assign eff_run_c = (mfi_source_switch && dip_off) ? q.run_sec : q.run_pri;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [31:0] wr;
		logic [2:0] ev;
		logic rd_clear;
		wr = 32'h0;
		ev = 3'h0;
		rd_clear = 1'b0;
		d = q;
		d.frame_accept = 1'b0;
		d.frame_write_ok = 1'b0;
		d.tx_start = 1'b0;
		// bus write
		if (q.awready && s_axi_awvalid) begin
			d.awready = 1'b0;
			d.awaddr = s_axi_awaddr;
			d.aw_got = 1'b1;
		end
		if (q.wready && s_axi_wvalid) begin
			d.wready = 1'b0;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
			d.w_got = 1'b1;
		end
		if (q.aw_got && q.w_got) begin
			wr = reg_value(q.awaddr, q);
			for (int i = 0; i < 4; i++) begin
				if (q.wstrb[i]) begin
					wr[i*8 +: 8] = q.wdata[i*8 +: 8];
				end
			end
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = addr_known(q.awaddr) ? modbus_cfg_pkg::RESP_OKAY : modbus_cfg_pkg::RESP_SLVERR;
			case (q.awaddr)
				modbus_cfg_pkg::OFS_STATION: d.addr_pend = wr[4:0];
				modbus_cfg_pkg::OFS_BAUD: begin
					if (wr[3:0] <= modbus_cfg_pkg::BAUD_MAX) begin
						d.baud_pend = wr[3:0];
					end
				end
				modbus_cfg_pkg::OFS_FORMAT: begin
					if (wr[3:0] <= modbus_cfg_pkg::FMT_MAX) begin
						d.frame_fmt = wr[3:0];
					end
				end
				modbus_cfg_pkg::OFS_TIMEOUT: begin
					if (wr[7:0] <= modbus_cfg_pkg::TIMEOUT_MAX) begin
						d.timeout = wr[6:0];
					end
				end
				modbus_cfg_pkg::OFS_TURN: d.turnaround = wr[7:0];
				modbus_cfg_pkg::OFS_ACTION: d.fault_action = wr[1:0];
				modbus_cfg_pkg::OFS_SOURCE: begin
					if (wr[modbus_cfg_pkg::FREQ_PRI_LSB +: 3] <= modbus_cfg_pkg::FREQ_SRC_MAX) begin
						d.freq_pri = wr[modbus_cfg_pkg::FREQ_PRI_LSB +: 3];
					end
					if (wr[modbus_cfg_pkg::RUN_PRI_LSB +: 2] <= modbus_cfg_pkg::RUN_SRC_MAX) begin
						d.run_pri = wr[modbus_cfg_pkg::RUN_PRI_LSB +: 2];
					end
					if (wr[modbus_cfg_pkg::FREQ_SEC_LSB +: 3] <= modbus_cfg_pkg::FREQ_SRC_MAX) begin
						d.freq_sec = wr[modbus_cfg_pkg::FREQ_SEC_LSB +: 3];
					end
					if (wr[modbus_cfg_pkg::RUN_SEC_LSB +: 2] <= modbus_cfg_pkg::RUN_SRC_MAX) begin
						d.run_sec = wr[modbus_cfg_pkg::RUN_SEC_LSB +: 2];
					end
				end
				modbus_cfg_pkg::OFS_IRQ_MASK: d.irq_mask = wr[2:0];
				default: d.bresp = d.bresp;
			endcase
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end
		// bus read
		if (q.arready && s_axi_arvalid) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = reg_value(s_axi_araddr, q);
			d.rresp = addr_known(s_axi_araddr) ? modbus_cfg_pkg::RESP_OKAY : modbus_cfg_pkg::RESP_SLVERR;
			rd_clear = (s_axi_araddr == modbus_cfg_pkg::OFS_IRQ_STS);
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
		// settings that only a power-up brings in
		if (power_up_reload) begin
			d.addr_act = q.addr_pend;
			d.baud_act = q.baud_pend;
		end
		// character framing decode
		d.ascii = (q.frame_fmt >= modbus_cfg_pkg::FMT_ASCII8);
		d.data7 = (q.frame_fmt >= modbus_cfg_pkg::FMT_ASCII7);
		d.two_stop = (q.frame_fmt[1:0] == 2'h0);
		d.par_en = q.frame_fmt[1];
		d.par_odd = (q.frame_fmt[1:0] == 2'h3);
		// accepted frames; communication parameters stay local
		d.frame_accept = frame_match;
		d.frame_write_ok = frame_match && !frame_in.writes_comm;
		// loss supervision
		if (!loss_en || frame_match) begin
			d.comm_fault = 1'b0;
		end else if (loss_zero) begin
			d.comm_fault = 1'b1;
		end
		ev[modbus_cfg_pkg::IRQ_FAULT] = loss_en && loss_zero && !frame_match && !q.comm_fault;
		ev[modbus_cfg_pkg::IRQ_ACCEPT] = frame_match;
		ev[modbus_cfg_pkg::IRQ_DROP] = frame_in.done && !frame_match;
		// turnaround before reply
		case (q.ta_state)
			modbus_cfg_pkg::TA_IDLE: begin
				if (frame_match) begin
					d.ta_state = modbus_cfg_pkg::TA_WAIT;
				end
			end
			modbus_cfg_pkg::TA_WAIT: begin
				if (!frame_match && turn_zero) begin
					d.ta_state = modbus_cfg_pkg::TA_READY;
				end
			end
			modbus_cfg_pkg::TA_READY: begin
				if (frame_match) begin
					d.ta_state = modbus_cfg_pkg::TA_WAIT;
				end else if (tx_request) begin
					d.tx_start = 1'b1;
					d.ta_state = modbus_cfg_pkg::TA_IDLE;
				end
			end
			default: d.ta_state = modbus_cfg_pkg::TA_IDLE;
		endcase
		// command sources
		d.eff_freq = eff_freq_c;
		d.eff_run = eff_run_c;
		d.modbus_freq = (eff_freq_c == modbus_cfg_pkg::FREQ_MODBUS);
		d.modbus_run = (eff_run_c == modbus_cfg_pkg::RUN_MODBUS);
		// interrupts, set wins over read clear
		d.irq_sts = (rd_clear ? 3'h0 : q.irq_sts) | ev;
		d.irq = |(d.irq_sts & d.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= modbus_cfg_pkg::TOP_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;
	assign frame_accept = q.frame_accept;
	assign frame_write_ok = q.frame_write_ok;
	assign tx_start = q.tx_start;
	assign baud_select = q.baud_act;
	assign ascii_mode = q.ascii;
	assign data_bits_7 = q.data7;
	assign parity_en = q.par_en;
	assign parity_odd = q.par_odd;
	assign two_stop = q.two_stop;
	assign comm_fault = q.comm_fault;
	assign comm_fault_action = q.fault_action;
	assign freq_ref_source = q.eff_freq;
	assign run_cmd_source = q.eff_run;
	assign modbus_freq_sel = q.modbus_freq;
	assign modbus_run_sel = q.modbus_run;
	assign irq = q.irq;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_addr_match: assert property (@(posedge aclk) disable iff (!aresetn)
		q.frame_accept |-> $past(frame_in.done && frame_in.crc_ok && frame_in.addr == {3'h0, q.addr_act}))
		else $error("frame accepted with foreign address");
	a_zero_silent: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.addr_act == 5'h00) |=> !q.frame_accept)
		else $error("frame accepted while station address zero");
	a_active_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!power_up_reload |=> $stable(q.addr_act) && $stable(q.baud_act))
		else $error("active address or baud changed without reload");
	a_baud_range: assert property (@(posedge aclk) disable iff (!aresetn)
		q.baud_pend <= modbus_cfg_pkg::BAUD_MAX)
		else $error("baud selector out of range");
	a_rtu_decode: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.frame_fmt == 4'h1) |=> !q.ascii && !q.data7 && !q.par_en && !q.two_stop)
		else $error("rtu 8n1 decode wrong");
	a_ascii_decode: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.frame_fmt >= modbus_cfg_pkg::FMT_ASCII8) |=> q.ascii && (q.data7 == $past(q.frame_fmt[3])))
		else $error("ascii decode wrong");
	a_fmt_range: assert property (@(posedge aclk) disable iff (!aresetn)
		q.frame_fmt <= modbus_cfg_pkg::FMT_MAX)
		else $error("frame format out of range");
	a_timeout_range: assert property (@(posedge aclk) disable iff (!aresetn)
		{1'b0, q.timeout} <= modbus_cfg_pkg::TIMEOUT_MAX)
		else $error("loss timeout out of range");
	a_fault_raise: assert property (@(posedge aclk) disable iff (!aresetn)
		(loss_en && loss_zero && !frame_match) |=> q.comm_fault)
		else $error("loss not flagged as fault");
	a_turn_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		q.tx_start |-> $past(q.ta_state == modbus_cfg_pkg::TA_READY && tx_request, 1))
		else $error("transmit started before turnaround");
	a_freq_src: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> q.modbus_freq == $past(eff_freq_c == modbus_cfg_pkg::FREQ_MODBUS))
		else $error("modbus frequency select wrong");
	a_run_sec: assert property (@(posedge aclk) disable iff (!aresetn)
		(mfi_source_switch && dip_off) |=> q.eff_run == $past(q.run_sec))
		else $error("secondary run source not applied");
	a_loss_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		!loss_en |=> !q.comm_fault)
		else $error("fault while loss detection disabled");

endmodule

// ---- tb/modbus_master_model.sv ----
// master stand-in: frame reports toward the slave and reply readiness
// assumes send is called just after a rising edge of aclk
`timescale 1ns/1ps
module modbus_master_model (
	// clock
	input wire logic aclk,
	// frame link
	output modbus_cfg_pkg::frame_in_s frame_in,
	output logic tx_request,
	input wire logic frame_accept,
	input wire logic frame_write_ok,
	input wire logic tx_start
);
	int acc_n = 0;
	int wok_n = 0;
	initial frame_in = '0;
	initial tx_request = 1'b0;
	////////////////////////////////////////
	// one frame report, station 0..31 only
	task automatic send(input logic [4:0] a, input logic ok, input logic wc);
		frame_in <= '{1'b1, ok, wc, {3'h0, a}};
		@(posedge aclk);
		frame_in <= '{1'b0, ~ok, ~wc, {3'h7, ~a}};
		repeat (2) @(posedge aclk);
	endtask
	// reply ready after each accept, held until tx_start
	always @(posedge aclk) begin
		if (frame_accept) acc_n <= acc_n + 1;
		if (frame_write_ok) wok_n <= wok_n + 1;
		if (frame_accept) tx_request <= 1'b1;
		else if (tx_start) tx_request <= 1'b0;
	end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the modbus slave link configuration block
// assumes the master model beside it and short timer ticks
`timescale 1ns/1ps
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b1;
	logic power_up_reload = 1'b0;
	logic mfi_source_switch = 1'b0;
	logic dip_off = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, comm_fault_action, run_cmd_source, rr;
	logic [31:0] s_axi_rdata, rv;
	logic tx_request, frame_accept, frame_write_ok, tx_start, comm_fault;
	logic ascii_mode, data_bits_7, parity_en, parity_odd, two_stop, modbus_freq_sel, modbus_run_sel;
	logic [3:0] baud_select;
	logic [2:0] freq_ref_source;
	modbus_cfg_pkg::frame_in_s frame_in;
	int fails = 0;
	int check_count = 0;
	int n;
	modbus_slave_link_config #(.LOSS_TICK_CYCLES(20), .TURN_TICK_CYCLES(10)) dut (.*);
	modbus_master_model m (.*);
	always #2.5 aclk = ~aclk;
	////////////////////////////////////////
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk({rr, rv}, {2'h0, e});
	endtask
	task automatic reload;
		power_up_reload <= 1'b1;
		tick(1);
		power_up_reload <= 1'b0;
		tick(2);
	endtask
	function automatic logic [4:0] fmt_exp(input int f);
		return {f > 3, f > 7, f % 4 == 0, f % 4 > 1, f % 4 == 3};
	endfunction
	////////////////////////////////////////
	task automatic t_defaults;
		rchk(8'h00, 32'h1);
		rchk(8'h04, 32'h3);
		rchk(8'h08, 32'h1);
		rchk(8'h0C, 32'h0);
		rchk(8'h18, 32'h11);
		rchk(8'h1C, 32'h301);
		chk(baud_select, 4'h3);
		chk({freq_ref_source, run_cmd_source}, 5'h05);
	endtask
	task automatic t_formats;
		for (int f = 0; f < 13; f++) begin
			wr(8'h08, 32'(f), 2'h0);
			tick(2);
			chk({ascii_mode, data_bits_7, two_stop, parity_en, parity_odd}, fmt_exp(f > 11 ? 11 : f));
		end
	endtask
	task automatic t_station;
		wr(8'h00, 32'h7, 2'h0);
		wr(8'h04, 32'h5, 2'h0);
		wr(8'h04, 32'h9, 2'h0);
		rchk(8'h04, 32'h5);
		chk(baud_select, 4'h3);
		m.send(5'h7, 1'b1, 1'b0);
		chk(m.acc_n, 0);
		reload();
		rchk(8'h1C, 32'hF507);
		chk(baud_select, 4'h5);
		m.send(5'h7, 1'b1, 1'b0);
		m.send(5'h7, 1'b0, 1'b0);
		m.send(5'h1, 1'b1, 1'b0);
		chk(m.acc_n, 1);
		rchk(8'h20, 32'h6);
		rchk(8'h20, 32'h0);
		wr(8'h24, 32'h2, 2'h0);
		m.send(5'h7, 1'b1, 1'b0);
		tick(2);
		chk(irq, 1'b1);
		rchk(8'h20, 32'h2);
		tick(2);
		chk(irq, 1'b0);
		m.send(5'h7, 1'b1, 1'b1);
		chk({m.acc_n, m.wok_n}, {32'd3, 32'd2});
		wr(8'h00, 32'h0, 2'h0);
		reload();
		m.send(5'h0, 1'b1, 1'b0);
		chk(m.acc_n, 3);
		wr(8'h00, 32'h7, 2'h0);
		reload();
	endtask
	task automatic t_loss;
		wr(8'h14, 32'h2, 2'h0);
		wr(8'h0C, 32'h65, 2'h0);
		rchk(8'h0C, 32'h0);
		wr(8'h0C, 32'h2, 2'h0);
		wr(8'h24, 32'h1, 2'h0);
		chk({comm_fault, irq}, 2'h0);
		rchk(8'h20, 32'h6);
		m.send(5'h7, 1'b1, 1'b0);
		tick(15);
		chk(comm_fault, 1'b0);
		for (int i = 0; i < 60 && comm_fault !== 1'b1; i++) tick(1);
		chk({comm_fault, comm_fault_action, irq}, 4'hD);
		m.send(5'h7, 1'b1, 1'b0);
		chk(comm_fault, 1'b0);
		wr(8'h0C, 32'h0, 2'h0);
		tick(100);
		chk(comm_fault, 1'b0);
	endtask
	task automatic t_turn;
		for (int d = 0; d < 4; d += 3) begin
			wr(8'h10, 32'(d), 2'h0);
			m.send(5'h7, 1'b1, 1'b0);
			n = 0;
			while (tx_start !== 1'b1 && n < 60) begin
				tick(1);
				n++;
			end
			chk(n >= d * 6 && n <= d * 10 + 6, 1'b1);
		end
	endtask
	task automatic t_sources;
		wr(8'h18, 32'h423, 2'h0);
		tick(2);
		chk({freq_ref_source, run_cmd_source, modbus_freq_sel, modbus_run_sel}, 7'h3B);
		mfi_source_switch <= 1'b1;
		dip_off <= 1'b1;
		tick(3);
		chk({freq_ref_source, run_cmd_source, modbus_freq_sel, modbus_run_sel}, 7'h40);
		dip_off <= 1'b0;
		tick(3);
		chk({freq_ref_source, run_cmd_source, modbus_freq_sel, modbus_run_sel}, 7'h3B);
		wr(8'h18, 32'h25, 2'h0);
		rchk(8'h18, 32'h23);
	endtask
	task automatic t_unmapped;
		wr(8'h30, 32'h0, 2'h2);
		rd(8'h30);
		chk({rr, rv}, {2'h2, 32'h0});
	endtask
	task automatic print_verdict;
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		tick(3);
		aresetn <= 1'b1;
		tick(1);
		t_defaults();
		t_formats();
		t_station();
		t_loss();
		t_turn();
		t_sources();
		t_unmapped();
		print_verdict();
	end
	initial begin
		#50us;
		fails++;
		print_verdict();
	end
endmodule
